// file: core/timer_pkg.sv
// shared constants and carrier types of the triple timer unit
package timer_pkg;

   // ------------------------------------------------------------
   // bus carrier
   // ------------------------------------------------------------
   typedef struct packed {
      logic [11:0] address;
      logic read;
      logic write;
      logic [3:0] byteenable;
      logic [31:0] writedata;
   } bus_req_s;

   typedef enum logic [0:0] {
      BUS_IDLE = 1'b0,
      BUS_ACK = 1'b1
   } bus_state_e;

   // ------------------------------------------------------------
   // register indices (byte address is index times four)
   // ------------------------------------------------------------
   localparam logic [9:0] IDX_PORT_MODE_A = 10'h004;
   localparam logic [9:0] IDX_TIMER_A_MODE = 10'h008;
   localparam logic [9:0] IDX_TIMER_B_MODE_ONE = 10'h009;
   localparam logic [9:0] IDX_TIMER_B_LOW = 10'h00a;
   localparam logic [9:0] IDX_TIMER_B_HIGH = 10'h00b;
   localparam logic [9:0] IDX_TIMER_C_MODE = 10'h00d;
   localparam logic [9:0] IDX_TIMER_C_LOW = 10'h00e;
   localparam logic [9:0] IDX_TIMER_C_HIGH = 10'h00f;
   localparam logic [9:0] IDX_WATCHDOG_CTRL = 10'h010;
   localparam logic [9:0] IDX_TIMER_B_MODE_TWO = 10'h026;

   // ------------------------------------------------------------
   // fields and reset values
   // ------------------------------------------------------------
   localparam int PWM_PIN_SELECT_BIT = 2;
   localparam int RELOAD_BIT = 3;
   localparam int CAPTURE_BIT = 2;
   localparam int WATCHDOG_BIT = 0;
   localparam logic [2:0] SRC_EVENT = 3'h7;
   localparam logic [1:0] EDGE_NONE = 2'h0;
   localparam logic [1:0] EDGE_FALL = 2'h1;
   localparam logic [1:0] EDGE_RISE = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
   localparam logic [3:0] MODE_RESET = 4'h0;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] COUNT_TOP = 8'hff;

   // ------------------------------------------------------------
   // prescaler taps: divide by 2,4,8,16,32,64,256,1024
   // ------------------------------------------------------------
   localparam int PS_W = 11;
   localparam logic [PS_W-1:0] PS_RESET = 11'h000;
   localparam logic [7:0][PS_W-1:0] TAP_MASK = {
      11'h3ff, 11'h0ff, 11'h03f, 11'h01f, 11'h00f, 11'h007, 11'h003, 11'h001
   };

endpackage

// file: core/triple_timer_unit.sv
// three 8-bit timers on a shared prescaler with an Avalon-MM register slave
//
// Operation
// - prescaler divides clock, taps feed timers
// - first timer: 8-bit up counter, tap select
// - first timer overflow raises interrupt request
// - second timer: free-run, reload, input capture
// - second mode one picks tap or event
// - second mode two picks event edge
// - second write registers load reload value
// - second read registers return live count, or the captured value in capture
// - capture counts tap ticks between trigger edges
// - second interrupts on overflow and capture edge
// - third timer: free-run, reload, watchdog
// - third mode register picks one tap
// - port mode bit 2 routes pwm pin
// - third write loads count, read returns live
// - third timer overflow raises interrupt request while the watchdog flag is clear
// - third counter usable as runaway watchdog
// - pwm takes new settings from next overflow
// - stop resets timers and the prescaler
// - watchdog flag cleared by reset, stop cancel
`timescale 1ns/1ns

module triple_timer_unit (
   input wire logic clock,
   input wire logic nrst,
   input wire timer_pkg::bus_req_s bus_req,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic event_capture_pin,
   input wire logic stop_mode,
   input wire logic stop_cancel_input_n,
   output logic irq_first,
   output logic irq_second,
   output logic irq_third,
   output logic mcu_reset_request,
   output logic pwm_output_pin
);

   // ------------------------------------------------------------
   // reset release and pin synchronisers
   // ------------------------------------------------------------
   logic rst_sync0;
   logic rst_n;
   logic ev_s0;
   logic ev_s1;
   logic ev_d;
   logic cn_s0;
   logic cn_s1;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rst_sync0 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_sync0 <= 1'b1;
         rst_n <= rst_sync0;
      end
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ev_s0 <= 1'b0;
         ev_s1 <= 1'b0;
         ev_d <= 1'b0;
         cn_s0 <= 1'b1;
         cn_s1 <= 1'b1;
      end else begin
         ev_s0 <= event_capture_pin;
         ev_s1 <= ev_s0;
         ev_d <= ev_s1;
         cn_s0 <= stop_cancel_input_n;
         cn_s1 <= cn_s0;
      end
   end

   // ------------------------------------------------------------
   // shared prescaler
   // ------------------------------------------------------------
   logic [timer_pkg::PS_W-1:0] prescale;
   logic [7:0] tick;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         prescale <= timer_pkg::PS_RESET;
      end else if (stop_mode) begin
         prescale <= timer_pkg::PS_RESET;
      end else begin
         prescale <= prescale + 11'h001;
      end
   end
   for (genvar i = 0; i < 8; i++) begin : g_tap
      assign tick[i] = (prescale & timer_pkg::TAP_MASK[i]) == timer_pkg::TAP_MASK[i];
   end
   // ------------------------------------------------------------
   // bus slave
   // ------------------------------------------------------------
   timer_pkg::bus_state_e bus_state;
   logic [9:0] idx;
   logic wr_fire;
   logic [3:0] wd4;
   logic [31:0] next_readdata;
   logic [3:0] port_mode_a;
   logic [3:0] timer_a_mode;
   logic [3:0] timer_b_mode_one;
   logic [3:0] timer_b_mode_two;
   logic [3:0] timer_c_mode;
   logic [3:0] b_low_stage;
   logic [3:0] c_low_stage;
   logic [7:0] b_reload;
   logic [7:0] c_reload;
   logic watchdog_enable_flag;
   logic [7:0] a_count;
   logic [7:0] b_count;
   logic [7:0] b_captured;
   logic [7:0] c_count;
   logic [7:0] b_view;
   assign idx = bus_req.address[11:2];
   assign wd4 = bus_req.writedata[3:0];
   assign wr_fire = (bus_state == timer_pkg::BUS_ACK) && bus_req.write && bus_req.byteenable[0];
   always_comb begin
      next_readdata = 32'h00000000;
      case (idx)
         timer_pkg::IDX_PORT_MODE_A: next_readdata[3:0] = port_mode_a;
         timer_pkg::IDX_TIMER_A_MODE: next_readdata[3:0] = timer_a_mode;
         timer_pkg::IDX_TIMER_B_MODE_ONE: next_readdata[3:0] = timer_b_mode_one;
         timer_pkg::IDX_TIMER_B_MODE_TWO: next_readdata[3:0] = timer_b_mode_two;
         timer_pkg::IDX_TIMER_B_LOW: next_readdata[3:0] = b_view[3:0];
         timer_pkg::IDX_TIMER_B_HIGH: next_readdata[3:0] = b_view[7:4];
         timer_pkg::IDX_TIMER_C_MODE: next_readdata[3:0] = timer_c_mode;
         timer_pkg::IDX_TIMER_C_LOW: next_readdata[3:0] = c_count[3:0];
         timer_pkg::IDX_TIMER_C_HIGH: next_readdata[3:0] = c_count[7:4];
         timer_pkg::IDX_WATCHDOG_CTRL: next_readdata[0] = watchdog_enable_flag;
         default: next_readdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         bus_state <= timer_pkg::BUS_IDLE;
         waitrequest <= 1'b1;
         readdata <= 32'h00000000;
      end else begin
         case (bus_state)
            timer_pkg::BUS_IDLE: begin
               if (bus_req.read || bus_req.write) begin
                  bus_state <= timer_pkg::BUS_ACK;
                  waitrequest <= 1'b0;
                  readdata <= next_readdata;
               end
            end
            timer_pkg::BUS_ACK: begin
               bus_state <= timer_pkg::BUS_IDLE;
               waitrequest <= 1'b1;
            end
            default: begin
               bus_state <= timer_pkg::BUS_IDLE;
               waitrequest <= 1'b1;
            end
         endcase
      end
   end

   a_bus_answer: assert property (@(posedge clock) disable iff (!rst_n)
      (bus_state == timer_pkg::BUS_IDLE) && (bus_req.read || bus_req.write)
      |=> !waitrequest ##1 waitrequest)
      else $error("bus answer not one cycle after request");

   // ------------------------------------------------------------
   // mode and write registers
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         port_mode_a <= timer_pkg::MODE_RESET;
         timer_a_mode <= timer_pkg::MODE_RESET;
         timer_b_mode_one <= timer_pkg::MODE_RESET;
         timer_b_mode_two <= timer_pkg::MODE_RESET;
         timer_c_mode <= timer_pkg::MODE_RESET;
      end else if (wr_fire) begin
         case (idx)
            timer_pkg::IDX_PORT_MODE_A: port_mode_a <= wd4;
            timer_pkg::IDX_TIMER_A_MODE: timer_a_mode <= wd4;
            timer_pkg::IDX_TIMER_B_MODE_ONE: timer_b_mode_one <= wd4;
            timer_pkg::IDX_TIMER_B_MODE_TWO: timer_b_mode_two <= wd4;
            timer_pkg::IDX_TIMER_C_MODE: timer_c_mode <= wd4;
            default: ;
         endcase
      end
   end

   // low nibble waits in a stage; the high write commits both nibbles
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         b_low_stage <= timer_pkg::MODE_RESET;
         c_low_stage <= timer_pkg::MODE_RESET;
         b_reload <= timer_pkg::COUNT_RESET;
         c_reload <= timer_pkg::COUNT_RESET;
      end else if (wr_fire) begin
         case (idx)
            timer_pkg::IDX_TIMER_B_LOW: b_low_stage <= wd4;
            timer_pkg::IDX_TIMER_B_HIGH: b_reload <= {wd4, b_low_stage};
            timer_pkg::IDX_TIMER_C_LOW: c_low_stage <= wd4;
            timer_pkg::IDX_TIMER_C_HIGH: c_reload <= {wd4, c_low_stage};
            default: ;
         endcase
      end
   end

   // software may only set the flag; a stop cancel clears it and wins
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         watchdog_enable_flag <= 1'b0;
      end else if (!cn_s1) begin
         watchdog_enable_flag <= 1'b0;
      end else if (wr_fire && idx == timer_pkg::IDX_WATCHDOG_CTRL && wd4[timer_pkg::WATCHDOG_BIT]) begin
         watchdog_enable_flag <= 1'b1;
      end
   end

   a_wdog_cancel: assert property (@(posedge clock) disable iff (!rst_n)
      !cn_s1 |=> !watchdog_enable_flag)
      else $error("watchdog flag survived stop cancel");
   // ------------------------------------------------------------
   // first timer
   // ------------------------------------------------------------
   logic a_tick;
   assign a_tick = tick[timer_a_mode[2:0]];
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         a_count <= timer_pkg::COUNT_RESET;
         irq_first <= 1'b0;
      end else begin
         irq_first <= !stop_mode && a_tick && a_count == timer_pkg::COUNT_TOP;
         if (stop_mode) begin
            a_count <= timer_pkg::COUNT_RESET;
         end else if (a_tick) begin
            a_count <= a_count + 8'h01;
         end
      end
   end
   a_first_count: assert property (@(posedge clock) disable iff (!rst_n)
      !stop_mode && a_tick |=> a_count == 8'($past(a_count) + 8'h01))
      else $error("first timer missed a tick");
   a_first_overflow: assert property (@(posedge clock) disable iff (!rst_n)
      !stop_mode && a_tick && a_count == 8'hff |=> irq_first && a_count == 8'h00)
      else $error("first timer overflow without request");
   // ------------------------------------------------------------
   // second timer: event source, edge select, capture
   // ------------------------------------------------------------
   logic b_cap;
   logic b_reload_mode;
   logic ev_edge;
   logic b_tick;
   logic b_over;
   logic b_load;
   assign b_cap = timer_b_mode_two[timer_pkg::CAPTURE_BIT];
   assign b_reload_mode = timer_b_mode_one[timer_pkg::RELOAD_BIT];
   assign b_load = wr_fire && idx == timer_pkg::IDX_TIMER_B_HIGH;
   always_comb begin
      case (timer_b_mode_two[1:0])
         timer_pkg::EDGE_FALL: ev_edge = !ev_s1 && ev_d;
         timer_pkg::EDGE_RISE: ev_edge = ev_s1 && !ev_d;
         timer_pkg::EDGE_BOTH: ev_edge = ev_s1 != ev_d;
         default: ev_edge = 1'b0;
      endcase
   end
   // in capture the count clock stays internal even with the event code set
   assign b_tick = (timer_b_mode_one[2:0] == timer_pkg::SRC_EVENT && !b_cap) ?
      ev_edge : tick[timer_b_mode_one[2:0]];
   assign b_over = b_tick && b_count == timer_pkg::COUNT_TOP;
   assign b_view = b_cap ? b_captured : b_count;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         b_count <= timer_pkg::COUNT_RESET;
         b_captured <= timer_pkg::COUNT_RESET;
         irq_second <= 1'b0;
      end else begin
         irq_second <= !stop_mode && (b_over || (b_cap && ev_edge));
         if (stop_mode) begin
            b_count <= timer_pkg::COUNT_RESET;
            b_captured <= timer_pkg::COUNT_RESET;
         end else if (b_load) begin
            b_count <= {wd4, b_low_stage};
         end else if (b_cap && ev_edge) begin
            b_captured <= b_count;
            b_count <= timer_pkg::COUNT_RESET;
         end else if (b_over) begin
            b_count <= b_reload_mode ? b_reload : timer_pkg::COUNT_RESET;
         end else if (b_tick) begin
            b_count <= b_count + 8'h01;
         end
      end
   end
   a_second_reload: assert property (@(posedge clock) disable iff (!rst_n)
      !stop_mode && !b_load && !(b_cap && ev_edge) && b_over && b_reload_mode
      |=> b_count == $past(b_reload))
      else $error("second timer did not reload");
   a_capture_edge: assert property (@(posedge clock) disable iff (!rst_n)
      !stop_mode && !b_load && b_cap && ev_edge
      |=> b_captured == $past(b_count) && b_count == 8'h00 && irq_second)
      else $error("capture edge mishandled");
   // ------------------------------------------------------------
   // third timer, pwm and watchdog
   // ------------------------------------------------------------
   logic c_tick;
   logic c_over;
   logic c_load;
   logic [7:0] c_active;
   assign c_tick = tick[timer_c_mode[2:0]];
   assign c_over = c_tick && c_count == timer_pkg::COUNT_TOP;
   assign c_load = wr_fire && idx == timer_pkg::IDX_TIMER_C_HIGH;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         c_count <= timer_pkg::COUNT_RESET;
      end else if (stop_mode) begin
         c_count <= timer_pkg::COUNT_RESET;
      end else if (c_load) begin
         c_count <= {wd4, c_low_stage};
      end else if (c_over) begin
         c_count <= timer_pkg::COUNT_RESET;
         if (timer_c_mode[timer_pkg::RELOAD_BIT]) begin
            c_count <= c_reload;
         end
      end else if (c_tick) begin
         c_count <= c_count + 8'h01;
      end
   end
   // the duty compare value moves only at overflow, and stop clears it
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         c_active <= timer_pkg::COUNT_RESET;
      end else if (stop_mode) begin
         c_active <= timer_pkg::COUNT_RESET;
      end else if (c_over) begin
         c_active <= c_reload;
      end
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         irq_third <= 1'b0;
         mcu_reset_request <= 1'b0;
         pwm_output_pin <= 1'b0;
      end else begin
         irq_third <= !stop_mode && c_over && !watchdog_enable_flag;
         mcu_reset_request <= !stop_mode && c_over && watchdog_enable_flag;
         pwm_output_pin <= port_mode_a[timer_pkg::PWM_PIN_SELECT_BIT] &&
            (c_count < c_active);
      end
   end
   a_watchdog_reset: assert property (@(posedge clock) disable iff (!rst_n)
      !stop_mode && c_over && watchdog_enable_flag |=> mcu_reset_request && !irq_third)
      else $error("watchdog overflow did not reset");
   a_third_irq: assert property (@(posedge clock) disable iff (!rst_n)
      !stop_mode && c_over && !watchdog_enable_flag |=> irq_third && !mcu_reset_request)
      else $error("third overflow without request");
   a_pwm_hold: assert property (@(posedge clock) disable iff (!rst_n)
      !stop_mode && !c_over |=> $stable(c_active))
      else $error("pwm setting changed between overflows");
   a_pin_route: assert property (@(posedge clock) disable iff (!rst_n)
      !port_mode_a[timer_pkg::PWM_PIN_SELECT_BIT] |=> !pwm_output_pin)
      else $error("pwm pin driven while not selected");
   a_stop_clears: assert property (@(posedge clock) disable iff (!rst_n)
      stop_mode |=> a_count == 8'h00 && b_count == 8'h00 && c_count == 8'h00)
      else $error("timers not held in reset during stop");
endmodule // triple_timer_unit

// file: sim/pin_partner.sv
// external event pin driver and pwm pin observer
`timescale 1ns/1ns

module pin_partner (
   input wire logic clock,
   output logic event_capture_pin,
   input wire logic pwm_output_pin,
   input wire logic pwm_sample
);
   int pwm_high = 0;

   initial begin
      event_capture_pin = 1'b0;
   end

   // pwm is only trusted inside the window the bench opens after an overflow
   always @(posedge clock) begin
      if (pwm_sample && pwm_output_pin === 1'b1) begin
         pwm_high <= pwm_high + 1;
      end
   end

   // one high pulse then low, each level held gap cycles; called just after an edge
   task automatic pulse(input int gap);
      event_capture_pin <= 1'b1;
      repeat (gap) @(posedge clock);
      event_capture_pin <= 1'b0;
      repeat (gap) @(posedge clock);
   endtask
endmodule // pin_partner

// file: sim/triple_timer_unit_bench.sv
// self-checking bench of the triple timer unit
`timescale 1ns/1ns

module triple_timer_unit_bench;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   timer_pkg::bus_req_s bus_req = '0;
   logic [31:0] readdata;
   logic waitrequest;
   logic event_capture_pin;
   logic stop_mode = 1'b0;
   logic stop_cancel_input_n = 1'b1;
   logic irq_first;
   logic irq_second;
   logic irq_third;
   logic mcu_reset_request;
   logic pwm_output_pin;
   logic pwm_sample = 1'b0;
   int error_cnt = 0;
   int compares = 0;
   int seed = 59;
   int irq2_cnt = 0;
   int irq3_cnt = 0;
   int model_reg [int];
   logic [9:0] modes [5] = '{timer_pkg::IDX_PORT_MODE_A, timer_pkg::IDX_TIMER_A_MODE,
      timer_pkg::IDX_TIMER_B_MODE_ONE, timer_pkg::IDX_TIMER_C_MODE,
      timer_pkg::IDX_TIMER_B_MODE_TWO};

   always #5 clock = ~clock;

   triple_timer_unit DUT (.clock(clock), .nrst(nrst), .bus_req(bus_req),
      .readdata(readdata), .waitrequest(waitrequest), .event_capture_pin(event_capture_pin),
      .stop_mode(stop_mode), .stop_cancel_input_n(stop_cancel_input_n),
      .irq_first(irq_first), .irq_second(irq_second), .irq_third(irq_third),
      .mcu_reset_request(mcu_reset_request), .pwm_output_pin(pwm_output_pin));

   pin_partner partner (.clock(clock), .event_capture_pin(event_capture_pin),
      .pwm_output_pin(pwm_output_pin), .pwm_sample(pwm_sample));

   always @(posedge clock) begin
      if (irq_second === 1'b1) irq2_cnt <= irq2_cnt + 1;
      if (irq_third === 1'b1) irq3_cnt <= irq3_cnt + 1;
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic int xorshift();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic pick(input int which);
      case (which)
         1: return irq_first;
         2: return irq_second;
         3: return irq_third;
         default: return mcu_reset_request;
      endcase
   endfunction

   task automatic check(input string what, input int expect_v, input int seen, input int tol);
      compares++;
      if (seen < expect_v - tol || seen > expect_v + tol) begin
         error_cnt++;
         $display("mismatch %s expected %0d seen %0d", what, expect_v, seen);
      end
   endtask

   task automatic print_verdict();
      $display("mismatches %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // avalon master: hold request until waitrequest sampled low, then release
   task automatic bus(input logic wr, input logic [9:0] idx, input logic [3:0] d,
         output logic [31:0] rd);
      bus_req.address <= {idx, 2'b00};
      bus_req.write <= wr;
      bus_req.read <= ~wr;
      bus_req.writedata <= {28'h0, d};
      bus_req.byteenable <= 4'h1;
      @(posedge clock);
      while (waitrequest !== 1'b0) @(posedge clock);
      rd = readdata;
      bus_req.write <= 1'b0;
      bus_req.read <= 1'b0;
      @(posedge clock);
   endtask

   task automatic wr(input logic [9:0] idx, input logic [3:0] d);
      logic [31:0] rd;
      bus(1'b1, idx, d, rd);
      model_reg[idx] = d;
   endtask

   task automatic rd_chk(input string what, input logic [9:0] idx, input int expect_v);
      logic [31:0] rd;
      bus(1'b0, idx, 4'h0, rd);
      check(what, expect_v, (^rd === 1'bx) ? -1 : int'(rd), 0);
   endtask

   // 8-bit value: low staged first, high commits both
   task automatic wr8(input logic [9:0] lo, input logic [7:0] v);
      wr(lo, v[3:0]);
      wr(lo + 10'h1, v[7:4]);
   endtask

   task automatic rd8(input logic [9:0] lo, output int v);
      logic [31:0] a;
      logic [31:0] b;
      bus(1'b0, lo + 10'h1, 4'h0, a);
      bus(1'b0, lo, 4'h0, b);
      v = (^{a, b} === 1'bx) ? -1 : int'({a[3:0], b[3:0]});
   endtask

   task automatic wait_pulse(input int which, output int n);
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pick(which) !== 1'b1 && n < 5000);
      if (n >= 5000) check("pulse wait", which, -1, 0);
   endtask

   task automatic do_reset();
      nrst <= 1'b0;
      repeat (4) @(posedge clock);
      nrst <= 1'b1;
      repeat (4) @(posedge clock);
      model_reg.delete();
      foreach (modes[i]) model_reg[modes[i]] = 0;
   endtask

   // ------------------------------------------------------------
   // watchdog and main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (60000) @(posedge clock);
      check("run time", 0, 1, 0);
      print_verdict();
   end

   initial begin
      int n;
      int v;
      int c0;
      do_reset();
      foreach (modes[i]) begin
         rd_chk("mode reset", modes[i], 0);
         wr(modes[i], xorshift() & 4'h7);
         rd_chk("mode readback", modes[i], model_reg[modes[i]]);
      end
      rd_chk("watchdog reset", timer_pkg::IDX_WATCHDOG_CTRL, 0);
      wr(10'h020, 4'hf);
      rd_chk("unmapped", 10'h020, 0);
      do_reset();
      for (int k = 0; k < 4; k++) begin
         // the tap only changes while stop holds the first timer
         stop_mode <= 1'b1;
         wr(timer_pkg::IDX_TIMER_A_MODE, k[3:0]);
         stop_mode <= 1'b0;
         wait_pulse(1, n);
         wait_pulse(1, n);
         check("timer a period", 256 * (2 << k), n, 0);
      end
      // reload of the second timer from a random value
      v = 8'hc0 | (xorshift() & 8'h3f);
      wr(timer_pkg::IDX_TIMER_B_MODE_ONE, 4'h8);
      wr8(timer_pkg::IDX_TIMER_B_LOW, v[7:0]);
      wait_pulse(2, n);
      wait_pulse(2, n);
      check("timer b reload period", (256 - v) * 2, n, 0);
      // event source with no edge: counter holds what was written
      wr(timer_pkg::IDX_TIMER_B_MODE_ONE, timer_pkg::SRC_EVENT);
      wr(timer_pkg::IDX_TIMER_B_MODE_TWO, timer_pkg::EDGE_NONE);
      v = xorshift() & 8'hff;
      wr8(timer_pkg::IDX_TIMER_B_LOW, v[7:0]);
      rd8(timer_pkg::IDX_TIMER_B_LOW, n);
      check("timer b read", v, n, 0);
      for (int e = 1; e < 4; e++) begin
         wr(timer_pkg::IDX_TIMER_B_MODE_TWO, e[3:0]);
         wr8(timer_pkg::IDX_TIMER_B_LOW, 8'h00);
         repeat (5) partner.pulse(6);
         repeat (8) @(posedge clock);
         rd8(timer_pkg::IDX_TIMER_B_LOW, n);
         check("event count", (e == 3) ? 10 : 5, n, 0);
      end
      // input capture on rising edges 100 cycles apart, divide-by-2 tap
      wr(timer_pkg::IDX_TIMER_B_MODE_ONE, 4'h0);
      wr(timer_pkg::IDX_TIMER_B_MODE_TWO, 4'h4 | timer_pkg::EDGE_RISE);
      partner.pulse(50);
      c0 = irq2_cnt;
      repeat (3) partner.pulse(50);
      repeat (10) @(posedge clock);
      check("capture irq count", 3, irq2_cnt - c0, 0);
      rd8(timer_pkg::IDX_TIMER_B_LOW, n);
      check("capture value", 50, n, 1);
      // pwm with duty 0x40 on free-running third timer
      do_reset();
      wr(timer_pkg::IDX_PORT_MODE_A, 4'h1 << timer_pkg::PWM_PIN_SELECT_BIT);
      wr8(timer_pkg::IDX_TIMER_C_LOW, 8'h40);
      wait_pulse(3, n);
      pwm_sample <= 1'b1;
      wait_pulse(3, n);
      pwm_sample <= 1'b0;
      // let the partner's count of this edge settle before reading it
      @(posedge clock);
      check("timer c period", 512, n, 0);
      check("pwm high cycles", 128, partner.pwm_high, 2);
      c0 = partner.pwm_high;
      wr(timer_pkg::IDX_PORT_MODE_A, 4'h0);
      pwm_sample <= 1'b1;
      repeat (600) @(posedge clock);
      pwm_sample <= 1'b0;
      check("pwm off", c0, partner.pwm_high, 0);
      // watchdog: overflow asks for reset, no interrupt
      c0 = irq3_cnt;
      wr(timer_pkg::IDX_WATCHDOG_CTRL, 4'h1);
      rd_chk("watchdog set", timer_pkg::IDX_WATCHDOG_CTRL, 1);
      wait_pulse(4, n);
      check("watchdog irq count", c0, irq3_cnt, 0);
      stop_cancel_input_n <= 1'b0;
      repeat (4) @(posedge clock);
      stop_cancel_input_n <= 1'b1;
      repeat (4) @(posedge clock);
      rd_chk("watchdog cleared", timer_pkg::IDX_WATCHDOG_CTRL, 0);
      // third timer reload from 0xc0 on the divide-by-2 tap
      wr(timer_pkg::IDX_TIMER_C_MODE, 4'h8);
      wr8(timer_pkg::IDX_TIMER_C_LOW, 8'hc0);
      wait_pulse(3, n);
      wait_pulse(3, n);
      check("timer c reload period", (256 - 8'hc0) * 2, n, 0);
      // slow tap live read, then stop mode clears the count
      wr(timer_pkg::IDX_TIMER_C_MODE, 4'h7);
      wr8(timer_pkg::IDX_TIMER_C_LOW, 8'h37);
      rd8(timer_pkg::IDX_TIMER_C_LOW, n);
      check("timer c live read", 8'h38, n, 1);
      stop_mode <= 1'b1;
      repeat (4) @(posedge clock);
      rd8(timer_pkg::IDX_TIMER_C_LOW, n);
      check("stop count", 0, n, 0);
      rd_chk("stop keeps mode", timer_pkg::IDX_TIMER_C_MODE, 7);
      stop_mode <= 1'b0;
      repeat (4) @(posedge clock);
      print_verdict();
   end
endmodule // triple_timer_unit_bench
